// File: hw/sbcs_consts.svh
`ifndef SBCS_CONSTS_SVH
`define SBCS_CONSTS_SVH

`define SBCS_CLK_PERIOD_NS 10
`define SBCS_NS2CYC(ns) ((((ns) + `SBCS_CLK_PERIOD_NS - 1) / `SBCS_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `SBCS_CLK_PERIOD_NS - 1) / `SBCS_CLK_PERIOD_NS))
`define SBCS_PRECHARGE_PERIOD_NS 20
`define SBCS_ACTIVATE_TO_ACCESS_NS 20
`define SBCS_REFRESH_CYCLE_NS 70
`define SBCS_MODE_LOAD_CYC 2
`define SBCS_SELF_REFRESH_EXIT_NS 70
`define SBCS_BURST_CYC 4
`define SBCS_CNT_W 8
`define SBCS_BANKS 4

`endif

// File: hw/sbcs_pkg.sv
package sbcs_pkg;

  typedef enum logic [3:0] {
    CMD_INHIBIT    = 4'h0,
    CMD_NOP        = 4'h1,
    CMD_ACTIVE     = 4'h2,
    CMD_READ       = 4'h3,
    CMD_WRITE      = 4'h4,
    CMD_PRECHARGE  = 4'h5,
    CMD_BURST_TERM = 4'h6,
    CMD_REFRESH    = 4'h7,
    CMD_LOAD_MODE  = 4'h8
  } sbcs_cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE        = 3'h0,
    BANK_ACTIVATING  = 3'h1,
    BANK_ACTIVE      = 3'h2,
    BANK_READ        = 3'h3,
    BANK_WRITE       = 3'h4,
    BANK_READ_AP     = 3'h5,
    BANK_WRITE_AP    = 3'h6,
    BANK_PRECHARGING = 3'h7
  } sbcs_bank_state_t;

  typedef enum logic [2:0] {
    DEV_NORMAL       = 3'h0,
    DEV_REFRESHING   = 3'h1,
    DEV_MODE_ACCESS  = 3'h2,
    DEV_PRE_ALL      = 3'h3,
    DEV_SELF_REFRESH = 3'h4,
    DEV_SR_EXIT      = 3'h5
  } sbcs_dev_state_t;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic auto_precharge_select_bit;
    logic bank_select_high;
    logic bank_select_low;
  } sbcs_pins_t;

endpackage

// File: hw/sbcs_bank.sv
`timescale 1ns/1ps
`include "sbcs_consts.svh"
module sbcs_bank
  import sbcs_pkg::*;
#(
  parameter int CNT_W   = `SBCS_CNT_W,
  parameter int TRP_C   = `SBCS_NS2CYC(`SBCS_PRECHARGE_PERIOD_NS),
  parameter int ACTIVATE_TO_ACCESS_DELAY_C  = `SBCS_NS2CYC(`SBCS_ACTIVATE_TO_ACCESS_NS),
  parameter int BURST_C = `SBCS_BURST_CYC
) (
  input  wire logic             core_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             go_in,
  input  wire sbcs_cmd_t        cmd_in,
  input  wire logic             ap_in,
  input  wire logic             pre_all_in,
  input  wire logic             term_in,
  output sbcs_bank_state_t      state_out,
  output logic                  bad_out
);

  sbcs_bank_state_t state;
  sbcs_bank_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             cnt_done;
  logic             bursting;
  logic             cmd_legal;

  assign cnt_done  = (cnt == CNT_W'(1));
  assign bursting  = (state == BANK_READ) || (state == BANK_WRITE);
  assign cmd_legal = ((state == BANK_IDLE) && (cmd_in == CMD_ACTIVE || cmd_in == CMD_PRECHARGE))
                  || ((state == BANK_ACTIVE || bursting)
                      && (cmd_in == CMD_READ || cmd_in == CMD_WRITE || cmd_in == CMD_PRECHARGE));
  assign bad_out   = go_in && !cmd_legal;
  assign state_out = state;

  always_comb begin
    next_state = state;
    next_cnt   = (cnt != CNT_W'(0)) ? cnt - CNT_W'(1) : cnt;
    if (pre_all_in && state != BANK_IDLE) begin
      next_state = BANK_PRECHARGING;
      next_cnt   = CNT_W'(TRP_C);
    end else if (go_in && cmd_legal) begin
      case (cmd_in)
        CMD_ACTIVE: begin
          next_state = BANK_ACTIVATING;
          next_cnt   = CNT_W'(ACTIVATE_TO_ACCESS_DELAY_C);
        end
        CMD_READ: begin
          next_state = ap_in ? BANK_READ_AP : BANK_READ;
          next_cnt   = ap_in ? CNT_W'(BURST_C + TRP_C) : CNT_W'(BURST_C);
        end
        CMD_WRITE: begin
          next_state = ap_in ? BANK_WRITE_AP : BANK_WRITE;
          next_cnt   = ap_in ? CNT_W'(BURST_C + TRP_C) : CNT_W'(BURST_C);
        end
        CMD_PRECHARGE: begin
          if (state != BANK_IDLE) begin
            next_state = BANK_PRECHARGING;
            next_cnt   = CNT_W'(TRP_C);
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (term_in && bursting) begin
      next_state = BANK_ACTIVE;
      next_cnt   = CNT_W'(0);
    end else if (cnt_done) begin
      case (state)
        BANK_ACTIVATING:  next_state = BANK_ACTIVE;
        BANK_READ:        next_state = BANK_ACTIVE;
        BANK_WRITE:       next_state = BANK_ACTIVE;
        BANK_PRECHARGING: next_state = BANK_IDLE;
        BANK_READ_AP:     next_state = BANK_IDLE;
        BANK_WRITE_AP:    next_state = BANK_IDLE;
        default:          next_state = state;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= BANK_IDLE;
      cnt   <= CNT_W'(0);
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_open_request;
    go_in && cmd_in == CMD_ACTIVE && state == BANK_IDLE && !pre_all_in;
  endsequence

  sequence s_auto_read;
    go_in && cmd_in == CMD_READ && ap_in && state == BANK_ACTIVE;
  endsequence

  activate_time_a: assert property (s_open_request |=> state == BANK_ACTIVATING
    ##ACTIVATE_TO_ACCESS_DELAY_C state == BANK_ACTIVE) else $error("activate delay wrong");
  precharge_idle_a: assert property (go_in && cmd_in == CMD_PRECHARGE
    && state == BANK_IDLE && !pre_all_in |=> state == BANK_IDLE)
    else $error("precharge of idle bank changed state");
  auto_read_a: assert property (s_auto_read |=> (state == BANK_READ_AP) [*1]
    ##(BURST_C + TRP_C) state == BANK_IDLE) else $error("auto precharge read timing wrong");
  bad_hold_a: assert property (bad_out && state == BANK_ACTIVE && !pre_all_in
    |=> state == BANK_ACTIVE) else $error("illegal command changed bank");
  close_row_a: assert property (go_in && cmd_in == CMD_PRECHARGE && state == BANK_ACTIVE
    |=> state == BANK_PRECHARGING ##TRP_C state == BANK_IDLE)
    else $error("row not closed by precharge");

endmodule

// File: hw/sbcs_top.sv
`timescale 1ns/1ps
`include "sbcs_consts.svh"
// Functional notes
// - Chip select high is command inhibit; ongoing operations continue untouched.
// - Select low with all three strobes high is no-operation; state continues.
// - Commands count only with clock enable high on previous and current edge, except a refresh with it low on the current edge (self refresh).
// - Bank is idle only after precharge period; only idle banks accept activate.
// - Precharge to an idle bank leaves it unchanged, acting as no-operation.
// - Row active means row open, delay met, no burst; reads and writes start bursts.
// - From row active, read and write start bursts, with or without auto precharge.
// - Precharge in row active closes the row and enters precharging.
// - During a plain read burst, read restarts and write switches to write burst.
// - During a plain write burst, write restarts and read switches to read burst.
// - Precharge during a plain read burst cuts it short and starts precharging.
// - Precharge during a plain write burst cuts it short and starts precharging.
// - Burst terminate stops the most recently started burst, in whichever bank, if that burst is a plain read or write burst.
// - Precharging lasts the precharge period; activating lasts the activate delay.
// - Auto precharge access holds the bank busy until precharge ends, then idle.
// - Refresh lasts refresh cycle time; mode access lasts mode-load delay; then idle.
// - Precharge-all lasts the precharge period and leaves every bank idle.
// - Any unlisted state and command pair is illegal and never produced.
// - Address bit ten high on read or write selects auto precharge.
// - Precharge with bit ten low hits the selected bank, high hits all banks.
// - Refresh encoding with clock enable sampled low enters self refresh.
module sbcs_top
  import sbcs_pkg::*;
#(
  parameter int CNT_W   = `SBCS_CNT_W,
  parameter int BANKS   = `SBCS_BANKS,
  parameter int TRP_C   = `SBCS_NS2CYC(`SBCS_PRECHARGE_PERIOD_NS),
  parameter int ACTIVATE_TO_ACCESS_DELAY_C  = `SBCS_NS2CYC(`SBCS_ACTIVATE_TO_ACCESS_NS),
  parameter int REFRESH_CYCLE_TIME_C  = `SBCS_NS2CYC(`SBCS_REFRESH_CYCLE_NS),
  parameter int MODE_LOAD_DELAY_C  = `SBCS_MODE_LOAD_CYC,
  parameter int SELF_REFRESH_EXIT_DELAY_C  = `SBCS_NS2CYC(`SBCS_SELF_REFRESH_EXIT_NS),
  parameter int BURST_C = `SBCS_BURST_CYC
) (
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    cs_n_in,
  input  wire logic                    ras_n_in,
  input  wire logic                    cas_n_in,
  input  wire logic                    we_n_in,
  input  wire logic                    cke_in,
  input  wire logic                    auto_precharge_select_bit_in,
  input  wire logic                    bank_select_high_in,
  input  wire logic                    bank_select_low_in,
  output sbcs_bank_state_t [BANKS-1:0] bank_state_out,
  output sbcs_dev_state_t              dev_state_out,
  output sbcs_cmd_t                    cmd_out,
  output logic                         violation_out
);

  sbcs_pins_t       pin_raw;
  sbcs_pins_t       pin_s1;
  sbcs_pins_t       pin_s2;
  sbcs_pins_t       pin_s3;
  sbcs_pins_t       cur;
  logic             stable;
  logic             cke_held;
  logic             cke_now;
  sbcs_cmd_t        strobe_cmd;
  sbcs_cmd_t        cmd;
  logic [1:0]       sel;
  logic             ap;
  logic             table_ok;
  logic             exec;
  logic             bank_cmd;
  logic             all_idle;
  logic             pre_all_ok;
  logic             pre_all;
  logic             term_ok;
  logic             sr_enter;
  logic             glob_bad;
  logic             any_bank_bad;
  logic             rw_start;
  logic             dev_busy;
  logic [1:0]       last_bank;
  logic             burst_seen;
  sbcs_dev_state_t  dev_state;
  sbcs_dev_state_t  next_dev_state;
  logic [CNT_W-1:0] dev_cnt;
  logic [CNT_W-1:0] next_dev_cnt;
  logic [BANKS-1:0] go;
  logic [BANKS-1:0] term;
  logic [BANKS-1:0] bank_bad;
  logic [BANKS-1:0] idle_bits;
  logic [BANKS-1:0] pre_ok_bits;
  logic [BANKS-1:0] burst_bits;

  assign pin_raw = '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in, we_n: we_n_in,
                     cke: cke_in, auto_precharge_select_bit: auto_precharge_select_bit_in,
                     bank_select_high: bank_select_high_in, bank_select_low: bank_select_low_in};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Pins count only once stages two and three agree
  assign stable   = (pin_s2 == pin_s3);
  assign cur      = pin_s3;
  assign cke_now  = stable ? cur.cke : cke_held;
  assign sel      = {cur.bank_select_high, cur.bank_select_low};
  assign ap       = cur.auto_precharge_select_bit;

  always_comb begin
    case ({cur.ras_n, cur.cas_n, cur.we_n})
      3'b111:  strobe_cmd = CMD_NOP;
      3'b011:  strobe_cmd = CMD_ACTIVE;
      3'b101:  strobe_cmd = CMD_READ;
      3'b100:  strobe_cmd = CMD_WRITE;
      3'b010:  strobe_cmd = CMD_PRECHARGE;
      3'b110:  strobe_cmd = CMD_BURST_TERM;
      3'b001:  strobe_cmd = CMD_REFRESH;
      default: strobe_cmd = CMD_LOAD_MODE;
    endcase
  end

  assign cmd      = (!stable || cur.cs_n) ? CMD_INHIBIT : strobe_cmd;
  assign table_ok = cke_held && cke_now && (dev_state == DEV_NORMAL);
  assign exec     = table_ok && (cmd != CMD_INHIBIT) && (cmd != CMD_NOP);
  assign bank_cmd = exec && ((cmd == CMD_ACTIVE) || (cmd == CMD_READ) || (cmd == CMD_WRITE)
                             || ((cmd == CMD_PRECHARGE) && !ap));
  assign all_idle   = &idle_bits;
  assign pre_all_ok = &pre_ok_bits;
  assign pre_all    = exec && (cmd == CMD_PRECHARGE) && ap && pre_all_ok;
  assign term_ok    = exec && (cmd == CMD_BURST_TERM) && burst_seen
                      && burst_bits[last_bank];
  assign sr_enter   = (dev_state == DEV_NORMAL) && cke_held && !cke_now
                      && (cmd == CMD_REFRESH) && all_idle;
  assign dev_busy   = (dev_state == DEV_REFRESHING) || (dev_state == DEV_MODE_ACCESS)
                      || (dev_state == DEV_PRE_ALL) || (dev_state == DEV_SR_EXIT);
  assign glob_bad   = (exec && (((cmd == CMD_REFRESH || cmd == CMD_LOAD_MODE) && !all_idle)
                                || (cmd == CMD_PRECHARGE && ap && !pre_all_ok)
                                || (cmd == CMD_BURST_TERM && !term_ok)))
                      || (dev_busy && cmd != CMD_INHIBIT && cmd != CMD_NOP);
  assign any_bank_bad = |bank_bad;
  assign rw_start     = bank_cmd && ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && !bank_bad[sel];

  genvar gi;
  generate
    for (gi = 0; gi < BANKS; gi++) begin : g_bank
      assign go[gi]          = bank_cmd && (sel == 2'(gi));
      assign term[gi]        = term_ok && (last_bank == 2'(gi));
      assign idle_bits[gi]   = (bank_state_out[gi] == BANK_IDLE);
      assign burst_bits[gi]  = (bank_state_out[gi] == BANK_READ)
                               || (bank_state_out[gi] == BANK_WRITE);
      assign pre_ok_bits[gi] = idle_bits[gi] || burst_bits[gi]
                               || (bank_state_out[gi] == BANK_ACTIVE);
      sbcs_bank #(
        .CNT_W   (CNT_W),
        .TRP_C   (TRP_C),
        .ACTIVATE_TO_ACCESS_DELAY_C  (ACTIVATE_TO_ACCESS_DELAY_C),
        .BURST_C (BURST_C)
      ) u_bank (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .go_in       (go[gi]),
        .cmd_in      (cmd),
        .ap_in       (ap),
        .pre_all_in  (pre_all),
        .term_in     (term[gi]),
        .state_out   (bank_state_out[gi]),
        .bad_out     (bank_bad[gi])
      );
    end
  endgenerate

  always_comb begin
    next_dev_state = dev_state;
    next_dev_cnt   = (dev_cnt != CNT_W'(0)) ? dev_cnt - CNT_W'(1) : dev_cnt;
    case (dev_state)
      DEV_NORMAL: begin
        if (sr_enter) begin
          next_dev_state = DEV_SELF_REFRESH;
        end else if (exec && !glob_bad) begin
          if (cmd == CMD_REFRESH) begin
            next_dev_state = DEV_REFRESHING;
            next_dev_cnt   = CNT_W'(REFRESH_CYCLE_TIME_C);
          end else if (cmd == CMD_LOAD_MODE) begin
            next_dev_state = DEV_MODE_ACCESS;
            next_dev_cnt   = CNT_W'(MODE_LOAD_DELAY_C);
          end else if (cmd == CMD_PRECHARGE && ap) begin
            next_dev_state = DEV_PRE_ALL;
            next_dev_cnt   = CNT_W'(TRP_C);
          end
        end
      end
      DEV_SELF_REFRESH: begin
        if (cke_now) begin
          next_dev_state = DEV_SR_EXIT;
          next_dev_cnt   = CNT_W'(SELF_REFRESH_EXIT_DELAY_C);
        end
      end
      default: begin
        if (dev_cnt == CNT_W'(1)) begin
          next_dev_state = DEV_NORMAL;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dev_state <= DEV_NORMAL;
      dev_cnt   <= CNT_W'(0);
      cke_held  <= 1'b0;
    end else begin
      dev_state <= next_dev_state;
      dev_cnt   <= next_dev_cnt;
      cke_held  <= cke_now;
    end
  end

  // Most recent burst owner for burst terminate
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_bank  <= 2'h0;
      burst_seen <= 1'b0;
    end else if (rw_start) begin
      last_bank  <= sel;
      burst_seen <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      violation_out <= 1'b0;
      cmd_out       <= CMD_INHIBIT;
    end else begin
      violation_out <= glob_bad || any_bank_bad;
      cmd_out       <= table_ok ? cmd : CMD_INHIBIT;
    end
  end

  assign dev_state_out = dev_state;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_refresh_taken;
    dev_state == DEV_NORMAL && next_dev_state == DEV_REFRESHING;
  endsequence

  sequence s_mode_taken;
    dev_state == DEV_NORMAL && next_dev_state == DEV_MODE_ACCESS;
  endsequence

  sequence s_busy_command;
    dev_state == DEV_REFRESHING && dev_cnt != CNT_W'(1) && cmd != CMD_INHIBIT && cmd != CMD_NOP;
  endsequence

  refresh_time_a: assert property (s_refresh_taken |=> dev_state == DEV_REFRESHING
    ##REFRESH_CYCLE_TIME_C dev_state == DEV_NORMAL && all_idle) else $error("refresh time wrong");
  mode_time_a: assert property (s_mode_taken |=> dev_state == DEV_MODE_ACCESS
    ##MODE_LOAD_DELAY_C dev_state == DEV_NORMAL) else $error("mode load time wrong");
  pre_all_idle_a: assert property ($fell(dev_state == DEV_PRE_ALL) |-> all_idle)
    else $error("banks not idle after precharge all");
  self_ref_entry_a: assert property (sr_enter |=> dev_state == DEV_SELF_REFRESH)
    else $error("self refresh not entered");
  busy_violation_a: assert property (s_busy_command |=> violation_out
    && $stable(dev_state)) else $error("busy command not flagged");
  inhibit_quiet_a: assert property (cmd == CMD_INHIBIT |-> go == '0 && !pre_all
    && term == '0) else $error("inhibit reached a bank");
  cke_gate_a: assert property (!(cke_held && cke_now) |=> cmd_out == CMD_INHIBIT)
    else $error("command taken with clock enable low");
  term_stop_a: assert property (term_ok && !pre_all |=>
    bank_state_out[$past(last_bank)] == BANK_ACTIVE) else $error("burst not terminated");

endmodule

// File: verification/sbcs_ctrl_model.sv
`timescale 1ns/1ps
module sbcs_ctrl_model
  import sbcs_pkg::*;
(
  input  wire logic core_clk_in,
  output sbcs_pins_t pins_out
);
  logic cke_lvl = 1'b1;

  initial pins_out = {4'h7, 1'b1, 3'h0};

  // Strobe order: select, row, column, write enable
  function automatic logic [3:0] enc(input sbcs_cmd_t c);
    case (c)
      CMD_NOP:        enc = 4'h7;
      CMD_ACTIVE:     enc = 4'h3;
      CMD_READ:       enc = 4'h5;
      CMD_WRITE:      enc = 4'h4;
      CMD_PRECHARGE:  enc = 4'h2;
      CMD_BURST_TERM: enc = 4'h6;
      CMD_REFRESH:    enc = 4'h1;
      CMD_LOAD_MODE:  enc = 4'h0;
      default:        enc = 4'h8;
    endcase
  endfunction

  // Holds a vector two cycles, then idles with released address inverted
  task automatic send_raw(input logic [7:0] v);
    pins_out = v;
    repeat (2) @(posedge core_clk_in);
    #1;
    pins_out = {enc(CMD_NOP), cke_lvl, ~v[2:0]};
  endtask

  // Ordering kept by the caller except in refusal cases
  task automatic send(input sbcs_cmd_t c, input logic ap, input logic [1:0] b);
    send_raw({enc(c), cke_lvl, ap, b});
  endtask
endmodule

// File: verification/sbcs_top_tb_top.sv
`timescale 1ns/1ps
module sbcs_top_tb_top
  import sbcs_pkg::*;
;
  typedef struct packed {
    sbcs_cmd_t c;
    logic      v;
  } sbcs_note_t;

  logic                       clk;
  logic                       rst_n;
  sbcs_pins_t                 pins;
  sbcs_bank_state_t [3:0]     bst;
  sbcs_dev_state_t            dst;
  sbcs_cmd_t                  cmd;
  logic                       viol;
  int                         n_fail;
  int                         compares;
  logic [31:0]                rng;
  sbcs_note_t                 notes[$];
  sbcs_note_t                 nt;

  sbcs_ctrl_model ctrl (.core_clk_in(clk), .pins_out(pins));

  sbcs_top #(.TRP_C(2), .ACTIVATE_TO_ACCESS_DELAY_C(2), .REFRESH_CYCLE_TIME_C(7), .SELF_REFRESH_EXIT_DELAY_C(2), .BURST_C(8)) dut (
    .core_clk_in                  (clk),
    .rst_n_in                     (rst_n),
    .cs_n_in                      (pins.cs_n),
    .ras_n_in                     (pins.ras_n),
    .cas_n_in                     (pins.cas_n),
    .we_n_in                      (pins.we_n),
    .cke_in                       (pins.cke),
    .auto_precharge_select_bit_in (pins.auto_precharge_select_bit),
    .bank_select_high_in          (pins.bank_select_high),
    .bank_select_low_in           (pins.bank_select_low),
    .bank_state_out               (bst),
    .dev_state_out                (dst),
    .cmd_out                      (cmd),
    .violation_out                (viol)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bank_is(input int b, input sbcs_bank_state_t e);
    chk($sformatf("bank%0d state", b), e, bst[b]);
  endtask

  task automatic dev_is(input sbcs_dev_state_t e);
    chk("device state", e, dst);
  endtask

  // Notes the expected decode, sends, returns once the state has landed
  task automatic issue(input sbcs_cmd_t c, input logic ap, input logic [1:0] b,
                       input logic v);
    notes.push_back({c, v});
    ctrl.send(c, ap, b);
    tick(2);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic ap_case(input sbcs_cmd_t c, input sbcs_bank_state_t e);
    issue(CMD_ACTIVE, 1'b0, 2'h2, 1'b0);
    tick(2);
    issue(c, 1'b1, 2'h2, 1'b0);
    bank_is(2, e);
    issue(CMD_ACTIVE, 1'b0, 2'h2, 1'b1);
    bank_is(2, e);
    tick(6);
    bank_is(2, BANK_IDLE);
  endtask

  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(negedge clk) begin
    if (rst_n && (viol !== 1'b0 || (cmd !== CMD_INHIBIT && cmd !== CMD_NOP))) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("ERROR decode expected none seen %h", cmd);
      end else begin
        nt = notes.pop_front();
        chk("decoded command", nt.c, cmd);
        chk("violation", nt.v, viol);
      end
    end
  end

  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end

  initial begin
    rst_n = 1'b0;
    n_fail = 0;
    compares = 0;
    rng = 32'h72d8_fc78;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(4);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      ctrl.send_raw({1'b1, rng[2:0], 1'b1, rng[5:3]});
      tick(1);
    end
    tick(4);
    for (int b = 0; b < 4; b++) bank_is(b, BANK_IDLE);
    issue(CMD_READ, 1'b0, 2'h0, 1'b1);
    bank_is(0, BANK_IDLE);
    issue(CMD_PRECHARGE, 1'b0, 2'h2, 1'b0);
    bank_is(2, BANK_IDLE);
    done("inhibit and idle");
    issue(CMD_ACTIVE, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_ACTIVATING);
    tick(2);
    bank_is(1, BANK_ACTIVE);
    issue(CMD_ACTIVE, 1'b0, 2'h1, 1'b1);
    bank_is(1, BANK_ACTIVE);
    issue(CMD_READ, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_READ);
    issue(CMD_WRITE, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_WRITE);
    issue(CMD_READ, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_READ);
    issue(CMD_READ, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_READ);
    issue(CMD_WRITE, 1'b0, 2'h1, 1'b0);
    issue(CMD_WRITE, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_WRITE);
    issue(CMD_BURST_TERM, 1'b0, 2'h3, 1'b0);
    bank_is(1, BANK_ACTIVE);
    issue(CMD_BURST_TERM, 1'b0, 2'h1, 1'b1);
    bank_is(1, BANK_ACTIVE);
    issue(CMD_READ, 1'b0, 2'h1, 1'b0);
    tick(8);
    bank_is(1, BANK_ACTIVE);
    done("bursts");
    for (int k = 0; k < 2; k++) begin
      issue(k == 0 ? CMD_READ : CMD_WRITE, 1'b0, 2'h1, 1'b0);
      issue(CMD_PRECHARGE, 1'b0, 2'h1, 1'b0);
      bank_is(1, BANK_PRECHARGING);
      tick(2);
      bank_is(1, BANK_IDLE);
      issue(CMD_ACTIVE, 1'b0, 2'h1, 1'b0);
      tick(2);
    end
    issue(CMD_PRECHARGE, 1'b0, 2'h1, 1'b0);
    bank_is(1, BANK_PRECHARGING);
    tick(2);
    bank_is(1, BANK_IDLE);
    done("precharge");
    ap_case(CMD_READ, BANK_READ_AP);
    ap_case(CMD_WRITE, BANK_WRITE_AP);
    done("auto precharge");
    issue(CMD_REFRESH, 1'b0, 2'h0, 1'b0);
    dev_is(DEV_REFRESHING);
    notes.push_back({CMD_INHIBIT, 1'b1});
    ctrl.send(CMD_ACTIVE, 1'b0, 2'h0);
    tick(2);
    bank_is(0, BANK_IDLE);
    tick(3);
    dev_is(DEV_NORMAL);
    issue(CMD_LOAD_MODE, 1'b0, 2'h0, 1'b0);
    dev_is(DEV_MODE_ACCESS);
    tick(2);
    dev_is(DEV_NORMAL);
    done("refresh and mode");
    issue(CMD_ACTIVE, 1'b0, 2'h3, 1'b0);
    tick(2);
    issue(CMD_REFRESH, 1'b0, 2'h0, 1'b1);
    dev_is(DEV_NORMAL);
    issue(CMD_PRECHARGE, 1'b1, 2'h0, 1'b0);
    dev_is(DEV_PRE_ALL);
    bank_is(3, BANK_PRECHARGING);
    tick(2);
    for (int b = 0; b < 4; b++) bank_is(b, BANK_IDLE);
    done("precharge all");
    ctrl.cke_lvl = 1'b0;
    ctrl.send(CMD_ACTIVE, 1'b0, 2'h0);
    tick(2);
    bank_is(0, BANK_IDLE);
    ctrl.cke_lvl = 1'b1;
    ctrl.send(CMD_NOP, 1'b0, 2'h0);
    tick(4);
    ctrl.cke_lvl = 1'b0;
    ctrl.send(CMD_REFRESH, 1'b0, 2'h0);
    tick(2);
    dev_is(DEV_SELF_REFRESH);
    ctrl.cke_lvl = 1'b1;
    ctrl.send(CMD_NOP, 1'b0, 2'h0);
    tick(2);
    dev_is(DEV_SR_EXIT);
    tick(2);
    dev_is(DEV_NORMAL);
    done("clock enable");
    chk("notes left", 8'h00, 8'(notes.size()));
    end_of_test;
  end
endmodule
